// File: dccw_channel.sv
// one dma channel steered by its control word, with width packing
// assumes an avalon-mm master on CLK; burst requests arrive from pins
//
// Summary of operation
// RULE1: Bit 25 picks bus master 1 (0) or 2 (1) for destination transfers.
// RULE2: Bit 24 picks bus master 1 (0) or 2 (1) for source transfers.
// RULE3: Software keeps the destination width no wider than its master bus.
// RULE4: Software keeps the source width no wider than its master bus.
// RULE5: Source and destination widths may differ; items are packed/split.
// RULE6: Each destination burst request allows dest_burst_len transfers.
// RULE7: Each source burst request allows src_burst_len transfers.
// RULE8: Software matches each burst length to the peripheral or memory.
// RULE9: The bus burst type does not follow the burst length fields.
// RULE10: Writing bits 11 to 0 sets the transfer count in flow-control mode.
// RULE11: The count falls per destination transfer; reads show what is left.
// RULE12: Software writes a zero count when a peripheral controls flow.
// RULE13: Software reads the count only after enabling and disabling.
// RULE14: Burst codes 0 to 7 mean 1, 4, 8, 16, 32, 64, 128 and 256.
// RULE15: Width codes 0, 1, 2 mean 8, 16, 32 bits; the rest are reserved.
// RULE16: A zero count in flow-control mode completes the item and stops.
`timescale 1ns/1ps
module dccw_channel
(
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic [3:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic SRC_BURST_REQUEST,
	input wire logic DST_BURST_REQUEST,
	input wire logic SRC_VALID,
	input wire logic [31:0] SRC_DATA,
	output logic SRC_READY,
	output logic DST_VALID,
	output logic [31:0] DST_DATA,
	input wire logic DST_READY,
	output logic SRC_MASTER_SEL,
	output logic DST_MASTER_SEL,
	output logic [2:0] BUS_BURST_TYPE,
	output logic ACTIVE,
	output logic ITEM_DONE
);

	dccw_pkg::dccw_ctrl_t ctrl_q;
	logic wait_q;
	logic flow_q;
	logic active_q;
	logic active_d;
	logic done_q;
	logic werr_q;
	logic [2:0] sreq_sync_q;
	logic [2:0] dreq_sync_q;
	logic sreq_lvl_q;
	logic dreq_lvl_q;
	logic src_rise;
	logic dst_rise;
	logic [8:0] scredit_q;
	logic [8:0] scredit_d;
	logic [8:0] dcredit_q;
	logic [63:0] acc_q;
	logic [63:0] acc_d;
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	logic [3:0] cnt_mid;
	logic [3:0] sb;
	logic [3:0] db;
	logic src_take;
	logic emit;
	logic buf_in_ready;
	logic buf_out_valid;
	logic [31:0] buf_out_data;
	logic buf_pop;
	logic dst_fire;
	logic wr_go;
	logic ctrl_wr;
	logic cmd_wr;
	logic stat_wr;
	logic start_ok;
	logic start_bad;
	logic stop_w;
	logic finish;
	logic count_dec;
	logic [31:0] rd_mux;

	assign wr_go = AVS_WRITE & ~wait_q;
	assign ctrl_wr = wr_go & (AVS_ADDRESS == dccw_pkg::ADDR_CTRL);
	assign cmd_wr = wr_go & (AVS_ADDRESS == dccw_pkg::ADDR_CMD)
		& AVS_BYTEENABLE[0];
	assign stat_wr = wr_go & (AVS_ADDRESS == dccw_pkg::ADDR_STAT)
		& AVS_BYTEENABLE[0];

	// avalon slave: one wait cycle, then the access completes
	always_comb
	begin
		if (AVS_ADDRESS == dccw_pkg::ADDR_CTRL)
			rd_mux = ctrl_q;
		else if (AVS_ADDRESS == dccw_pkg::ADDR_CMD)
			rd_mux = {30'h00000000, flow_q, active_q};
		else if (AVS_ADDRESS == dccw_pkg::ADDR_STAT)
			rd_mux = {29'h00000000, werr_q, done_q, active_q};
		else
			rd_mux = 32'h00000000;
	end

	always_ff @(posedge CLK)
	begin
		if (!RSTN)
		begin
			wait_q <= 1'b1;
			AVS_READDATA <= 32'h00000000;
		end
		else if (wait_q && (AVS_READ || AVS_WRITE))
		begin
			wait_q <= 1'b0;
			AVS_READDATA <= rd_mux;
		end
		else
			wait_q <= 1'b1;
	end

	assign AVS_WAITREQUEST = wait_q;

	// control word, with the count field doubling as the live counter
	assign sb = dccw_pkg::dccw_item_bytes(ctrl_q.src_item_width); // RULE15
	assign db = dccw_pkg::dccw_item_bytes(ctrl_q.dest_item_width); // RULE15
	assign dst_fire = DST_VALID & DST_READY;
	assign count_dec = dst_fire & flow_q & active_q
		& (ctrl_q.remaining_count != 12'h000); // RULE11 RULE12

	always_ff @(posedge CLK)
	begin
		if (!RSTN)
			ctrl_q <= dccw_pkg::CTRL_RESET;
		else if (ctrl_wr)
			ctrl_q <= dccw_pkg::dccw_merge(ctrl_q, AVS_WRITEDATA,
				AVS_BYTEENABLE); // RULE10
		else if (count_dec)
			ctrl_q.remaining_count <= ctrl_q.remaining_count - 12'h001; // RULE11
	end

	assign SRC_MASTER_SEL = ctrl_q.src_master; // RULE2
	assign DST_MASTER_SEL = ctrl_q.dst_master; // RULE1

	// channel enable, completion and error state
	assign start_ok = cmd_wr & AVS_WRITEDATA[dccw_pkg::CMD_EN_BIT]
		& ~active_q & (sb != 4'h0) & (db != 4'h0);
	assign start_bad = cmd_wr & AVS_WRITEDATA[dccw_pkg::CMD_EN_BIT]
		& ~active_q & ((sb == 4'h0) | (db == 4'h0)); // RULE15
	assign stop_w = cmd_wr & ~AVS_WRITEDATA[dccw_pkg::CMD_EN_BIT];
	assign finish = active_q & flow_q
		& ((ctrl_q.remaining_count == 12'h000)
		| ((ctrl_q.remaining_count == 12'h001) & dst_fire)); // RULE16

	always_comb
	begin
		active_d = active_q;
		if (start_ok)
			active_d = 1'b1;
		if (stop_w || finish)
			active_d = 1'b0;
	end

	always_ff @(posedge CLK)
	begin
		if (!RSTN)
		begin
			active_q <= 1'b0;
			flow_q <= 1'b0;
			ITEM_DONE <= 1'b0;
		end
		else
		begin
			active_q <= active_d;
			ITEM_DONE <= finish; // RULE16
			if (cmd_wr && !active_q)
				flow_q <= AVS_WRITEDATA[dccw_pkg::CMD_FLOW_BIT];
		end
	end

	assign ACTIVE = active_q;

	// sticky flags: a set in the clearing cycle wins
	always_ff @(posedge CLK)
	begin
		if (!RSTN)
		begin
			done_q <= 1'b0;
			werr_q <= 1'b0;
		end
		else
		begin
			if (finish)
				done_q <= 1'b1;
			else if (stat_wr && AVS_WRITEDATA[dccw_pkg::STAT_DONE_BIT])
				done_q <= 1'b0;
			if (start_bad)
				werr_q <= 1'b1;
			else if (stat_wr && AVS_WRITEDATA[dccw_pkg::STAT_WERR_BIT])
				werr_q <= 1'b0;
		end
	end

	// burst request pins: three stages, level taken once stages 2 and 3 agree
	always_ff @(posedge CLK)
	begin
		if (!RSTN)
		begin
			sreq_sync_q <= 3'h0;
			dreq_sync_q <= 3'h0;
			sreq_lvl_q <= 1'b0;
			dreq_lvl_q <= 1'b0;
		end
		else
		begin
			sreq_sync_q <= {sreq_sync_q[1:0], SRC_BURST_REQUEST};
			dreq_sync_q <= {dreq_sync_q[1:0], DST_BURST_REQUEST};
			if (sreq_sync_q[1] == sreq_sync_q[2])
				sreq_lvl_q <= sreq_sync_q[2];
			if (dreq_sync_q[1] == dreq_sync_q[2])
				dreq_lvl_q <= dreq_sync_q[2];
		end
	end

	assign src_rise = sreq_sync_q[1] & sreq_sync_q[2] & ~sreq_lvl_q;
	assign dst_rise = dreq_sync_q[1] & dreq_sync_q[2] & ~dreq_lvl_q;

	// burst credits: a request is honoured only once the last burst is used
	always_comb
	begin
		scredit_d = scredit_q;
		if (!active_d)
			scredit_d = 9'h000;
		else if (src_rise && scredit_q == 9'h000)
			scredit_d = dccw_pkg::dccw_burst_beats(
				ctrl_q.src_burst_len); // RULE7 RULE14
		else if (src_take)
			scredit_d = scredit_q - 9'h001; // RULE7
	end

	always_ff @(posedge CLK)
	begin
		if (!RSTN)
		begin
			scredit_q <= 9'h000;
			dcredit_q <= 9'h000;
		end
		else
		begin
			scredit_q <= scredit_d;
			if (!active_d)
				dcredit_q <= 9'h000;
			else if (dst_rise && dcredit_q == 9'h000)
				dcredit_q <= dccw_pkg::dccw_burst_beats(
					ctrl_q.dest_burst_len); // RULE6 RULE14
			else if (buf_pop)
				dcredit_q <= dcredit_q - 9'h001; // RULE6
		end
	end

	// packer: source items in at sb bytes, destination items out at db bytes
	assign src_take = SRC_VALID & SRC_READY;
	assign emit = active_q & (cnt_q >= db) & buf_in_ready; // RULE5

	always_comb
	begin
		acc_d = acc_q;
		cnt_mid = cnt_q;
		if (emit)
		begin
			acc_d = acc_q >> {db, 3'b000};
			cnt_mid = cnt_q - db;
		end
		cnt_d = cnt_mid;
		if (src_take)
		begin
			acc_d = acc_d | ({32'h00000000, SRC_DATA
				& dccw_pkg::dccw_byte_mask(sb)} << {cnt_mid, 3'b000}); // RULE5
			cnt_d = cnt_mid + sb;
		end
		if (start_ok)
		begin
			acc_d = 64'h0000000000000000;
			cnt_d = 4'h0;
		end
	end

	always_ff @(posedge CLK)
	begin
		if (!RSTN)
		begin
			acc_q <= 64'h0000000000000000;
			cnt_q <= 4'h0;
			SRC_READY <= 1'b0;
		end
		else
		begin
			acc_q <= acc_d;
			cnt_q <= cnt_d;
			SRC_READY <= active_d & (scredit_d != 9'h000)
				& (cnt_d <= dccw_pkg::ACC_ROOM);
		end
	end

	dccw_buf u_buf
	(
		.clk(CLK),
		.rst_n(RSTN),
		.in_valid(emit),
		.in_data(acc_q[31:0] & dccw_pkg::dccw_byte_mask(db)),
		.in_ready(buf_in_ready),
		.out_valid(buf_out_valid),
		.out_data(buf_out_data),
		.out_ready(buf_pop)
	);

	// output stage, loaded only against destination burst credit
	assign buf_pop = buf_out_valid & active_q & (dcredit_q != 9'h000)
		& (~DST_VALID | DST_READY);

	always_ff @(posedge CLK)
	begin
		if (!RSTN)
		begin
			DST_VALID <= 1'b0;
			DST_DATA <= 32'h00000000;
		end
		else if (buf_pop)
		begin
			DST_VALID <= 1'b1;
			DST_DATA <= buf_out_data;
		end
		else if (dst_fire)
			DST_VALID <= 1'b0;
	end

	// bus burst type is fixed, whatever the burst length fields hold
	always_ff @(posedge CLK)
	begin
		if (!RSTN)
			BUS_BURST_TYPE <= dccw_pkg::HBURST_INCR;
		else
			BUS_BURST_TYPE <= dccw_pkg::HBURST_INCR; // RULE9
	end

	chk_dst_master_sel: // RULE1
	assert property (@(posedge CLK) disable iff (!RSTN)
		ctrl_wr && AVS_BYTEENABLE[3] |=>
		DST_MASTER_SEL == $past(AVS_WRITEDATA[25]))
	else $error("destination master select not taken from write");

	chk_src_master_sel: // RULE2
	assert property (@(posedge CLK) disable iff (!RSTN)
		ctrl_wr && AVS_BYTEENABLE[3] |=>
		SRC_MASTER_SEL == $past(AVS_WRITEDATA[24]))
	else $error("source master select not taken from write");

	chk_pack_bound: // RULE5
	assert property (@(posedge CLK) disable iff (!RSTN)
		src_take |=> cnt_q <= 4'h8 && cnt_q >= $past(sb))
	else $error("packer byte count out of range");

	chk_dst_credit_load: // RULE6
	assert property (@(posedge CLK) disable iff (!RSTN)
		active_d && dst_rise && dcredit_q == 9'h000 |=>
		dcredit_q == dccw_pkg::dccw_burst_beats($past(ctrl_q.dest_burst_len)))
	else $error("destination burst credit wrong");

	chk_src_credit_load: // RULE7
	assert property (@(posedge CLK) disable iff (!RSTN)
		active_d && src_rise && scredit_q == 9'h000 |=>
		scredit_q == dccw_pkg::dccw_burst_beats($past(ctrl_q.src_burst_len)))
	else $error("source burst credit wrong");

	chk_burst_type_fixed: // RULE9
	assert property (@(posedge CLK) disable iff (!RSTN)
		$changed(ctrl_q) |=> BUS_BURST_TYPE == dccw_pkg::HBURST_INCR)
	else $error("bus burst type followed the control word");

	chk_count_load: // RULE10
	assert property (@(posedge CLK) disable iff (!RSTN)
		ctrl_wr && AVS_BYTEENABLE[1:0] == 2'h3 |=>
		ctrl_q.remaining_count == $past(AVS_WRITEDATA[11:0]))
	else $error("transfer count not loaded");

	chk_count_dec: // RULE11
	assert property (@(posedge CLK) disable iff (!RSTN)
		count_dec && !ctrl_wr |=>
		ctrl_q.remaining_count == $past(ctrl_q.remaining_count) - 12'h001)
	else $error("transfer count did not fall by one");

	chk_item_done: // RULE16
	assert property (@(posedge CLK) disable iff (!RSTN)
		active_q && flow_q && ctrl_q.remaining_count == 12'h001 && dst_fire
		|=> ITEM_DONE && !ACTIVE ##1 !ITEM_DONE)
	else $error("item not completed at zero count");

	chk_width_reserved: // RULE15
	assert property (@(posedge CLK) disable iff (!RSTN)
		start_bad |=> !ACTIVE && werr_q)
	else $error("reserved width started the channel");

endmodule

// File: dccw_pkg.sv
// constants, field layout and decode helpers of the channel control word
// assumes one channel, a 32-bit register bus and 32-bit data streams
package dccw_pkg;

	localparam int DATA_W = 32;
	localparam int ADDR_W = 4;

	// byte addresses of the register words
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_CMD = 4'h4;
	localparam logic [3:0] ADDR_STAT = 4'h8;

	// command word bits
	localparam int CMD_EN_BIT = 0;
	localparam int CMD_FLOW_BIT = 1;

	// status word bits
	localparam int STAT_ACTIVE_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam int STAT_WERR_BIT = 2;

	// item width codes
	localparam logic [2:0] WID_8 = 3'h0;
	localparam logic [2:0] WID_16 = 3'h1;
	localparam logic [2:0] WID_32 = 3'h2;

	// incrementing burst of undefined length on the bus side
	localparam logic [2:0] HBURST_INCR = 3'h1;

	// bytes the packer may hold before it stops taking source items
	localparam logic [3:0] ACC_ROOM = 4'h4;

	localparam logic [31:0] CTRL_RESET = 32'h00000000;

	typedef struct packed {
		logic [5:0] rsvd;
		logic dst_master;
		logic src_master;
		logic [2:0] dest_item_width;
		logic [2:0] src_item_width;
		logic [2:0] dest_burst_len;
		logic [2:0] src_burst_len;
		logic [11:0] remaining_count;
	} dccw_ctrl_t;

	function automatic logic [8:0] dccw_burst_beats(input logic [2:0] code);
		logic [8:0] n;
		n = 9'h001;
		case (code)
			3'h0: n = 9'h001;
			3'h1: n = 9'h004;
			3'h2: n = 9'h008;
			3'h3: n = 9'h010;
			3'h4: n = 9'h020;
			3'h5: n = 9'h040;
			3'h6: n = 9'h080;
			default: n = 9'h100;
		endcase
		return n;
	endfunction

	// zero means a reserved code
	function automatic logic [3:0] dccw_item_bytes(input logic [2:0] code);
		logic [3:0] n;
		n = 4'h0;
		case (code)
			WID_8: n = 4'h1;
			WID_16: n = 4'h2;
			WID_32: n = 4'h4;
			default: n = 4'h0;
		endcase
		return n;
	endfunction

	function automatic logic [31:0] dccw_byte_mask(input logic [3:0] nbytes);
		logic [31:0] m;
		m = 32'h00000000;
		case (nbytes)
			4'h1: m = 32'h000000FF;
			4'h2: m = 32'h0000FFFF;
			4'h4: m = 32'hFFFFFFFF;
			default: m = 32'h00000000;
		endcase
		return m;
	endfunction

	function automatic logic [31:0] dccw_merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
				r[i*8 +: 8] = wd[i*8 +: 8];
		end
		return r;
	endfunction

endpackage

// File: dccw_buf.sv
// two-entry buffer between the packer and the destination output stage
// assumes both sides on the same clock, synchronous active-low reset
`timescale 1ns/1ps
module dccw_buf
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	input wire logic [31:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [31:0] out_data,
	input wire logic out_ready
);

	logic [31:0] slot_q [2];
	logic wptr_q;
	logic rptr_q;
	logic [1:0] count_q;
	logic push;
	logic pop;

	assign in_ready = (count_q != 2'h2);
	assign out_valid = (count_q != 2'h0);
	assign out_data = slot_q[rptr_q];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_ff @(posedge clk)
	begin
		if (push)
			slot_q[wptr_q] <= in_data;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wptr_q <= 1'b0;
			rptr_q <= 1'b0;
			count_q <= 2'h0;
		end
		else
		begin
			if (push)
				wptr_q <= ~wptr_q;
			if (pop)
				rptr_q <= ~rptr_q;
			if (push && !pop)
				count_q <= count_q + 2'h1;
			else if (pop && !push)
				count_q <= count_q - 2'h1;
		end
	end

endmodule

// File: dccw_periph.sv
// source and destination peripherals facing one dma channel
// assumes the channel clock; the bench commands requests and stalls
`timescale 1ns/1ps
module dccw_periph
(
	input wire logic clk,
	input wire logic clr,
	input wire logic src_go,
	input wire logic dst_go,
	input wire logic stall,
	input wire logic src_ready,
	input wire logic dst_valid,
	input wire logic [31:0] dst_data,
	output logic src_burst_request,
	output logic dst_burst_request,
	output logic src_valid,
	output logic [31:0] src_data,
	output logic dst_ready
);
	logic [7:0] idx_q = 8'h00;
	logic [2:0] sreq_q = 3'h0;
	logic [2:0] dreq_q = 3'h0;
	logic [7:0] b;
	int nsrc = 0;
	logic [31:0] got[$];
	// request held long enough for the pin synchroniser
	assign src_burst_request = (sreq_q != 3'h0);
	assign dst_burst_request = (dreq_q != 3'h0);
	assign src_valid = 1'b1;
	// bytes 4n to 4n+3 of a running count, low byte first
	assign b = {idx_q[5:0], 2'b00};
	assign src_data = {b + 8'h03, b + 8'h02, b + 8'h01, b};
	assign dst_ready = !stall;
	always @(posedge clk)
	begin
		if (src_go)
			sreq_q <= 3'h4;
		else if (sreq_q != 3'h0)
			sreq_q <= sreq_q - 3'h1;
		if (dst_go)
			dreq_q <= 3'h4;
		else if (dreq_q != 3'h0)
			dreq_q <= dreq_q - 3'h1;
		if (clr)
			idx_q <= 8'h00;
		else if (src_ready && src_valid)
		begin
			idx_q <= idx_q + 8'h01;
			nsrc <= nsrc + 1;
		end
		if (dst_valid && dst_ready)
			got.push_back(dst_data);
	end
endmodule

// File: testbench.sv
// self-checking bench of the channel control word
// assumes the peripheral model and an avalon-mm master in this bench
`timescale 1ns/1ps
module testbench;
	localparam logic [3:0] A_CTRL = dccw_pkg::ADDR_CTRL;
	localparam logic [3:0] A_CMD = dccw_pkg::ADDR_CMD;
	localparam logic [3:0] A_STAT = dccw_pkg::ADDR_STAT;
	logic clk = 1'b0;
	logic rstn, rd, wr, waitreq, sbr, dbr, sval, sready, dval, dready;
	logic ssel, dsel, active, item_done, clr, src_go, dst_go, stall;
	logic [3:0] address, be;
	logic [31:0] wdata, rdata, sdata, ddata, r, e;
	logic [2:0] bbt;
	int errors = 0;
	int compares = 0;
	int cyc = 0;
	int ndone = 0;
	int n0, d0, m0, k;
	dccw_pkg::dccw_ctrl_t c;
	always #5 clk = ~clk;
	dccw_channel u_dut
	(
		.CLK(clk), .RSTN(rstn), .AVS_ADDRESS(address), .AVS_READ(rd),
		.AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be),
		.AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
		.SRC_BURST_REQUEST(sbr), .DST_BURST_REQUEST(dbr),
		.SRC_VALID(sval), .SRC_DATA(sdata), .SRC_READY(sready),
		.DST_VALID(dval), .DST_DATA(ddata), .DST_READY(dready),
		.SRC_MASTER_SEL(ssel), .DST_MASTER_SEL(dsel),
		.BUS_BURST_TYPE(bbt), .ACTIVE(active), .ITEM_DONE(item_done)
	);
	dccw_periph u_per
	(
		.clk(clk), .clr(clr), .src_go(src_go), .dst_go(dst_go),
		.stall(stall), .src_ready(sready), .dst_valid(dval),
		.dst_data(ddata), .src_burst_request(sbr),
		.dst_burst_request(dbr), .src_valid(sval), .src_data(sdata),
		.dst_ready(dready)
	);
	task results;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		compares = compares + 1;
		if (seen !== exp)
		begin
			errors = errors + 1;
			$display("ERROR at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		address <= a;
		wr <= w;
		rd <= !w;
		wdata <= d;
		be <= 4'hF;
		@(posedge clk);
		while (waitreq !== 1'b0)
			@(posedge clk);
		r = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task pulse(input logic s, input logic d);
		@(posedge clk);
		src_go <= s;
		dst_go <= d;
		@(posedge clk);
		src_go <= 1'b0;
		dst_go <= 1'b0;
	endtask
	task start(input logic [31:0] w, input logic [31:0] cmd);
		@(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		bus(1'b1, A_CTRL, w);
		bus(1'b1, A_CMD, cmd);
		n0 = u_per.nsrc;
		d0 = u_per.got.size();
		m0 = ndone;
	endtask
	always @(posedge clk)
	begin
		cyc = cyc + 1;
		if (item_done === 1'b1)
			ndone = ndone + 1;
		if (cyc == 20000)
		begin
			errors = errors + 1;
			results();
		end
	end
	initial
	begin
		rstn = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		address = 4'h0;
		wdata = 32'h0;
		be = 4'h0;
		clr = 1'b0;
		src_go = 1'b0;
		dst_go = 1'b0;
		stall = 1'b0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		bus(1'b0, A_CTRL, 32'h0);
		check(r, 32'h0);
		bus(1'b1, 4'hC, 32'hFFFFFFFF);
		bus(1'b0, 4'hC, 32'h0);
		check(r, 32'h0);
		for (k = 0; k < 4; k++)
		begin
			c = '0;
			c.dst_master = k[1];
			c.src_master = k[0];
			bus(1'b1, A_CTRL, c);
			bus(1'b0, A_CTRL, 32'h0);
			check(r, c);
			check({30'h0, dsel, ssel}, 32'(k));
		end
		for (k = 0; k < 8; k++)
		begin
			c = '0;
			c.dest_item_width = dccw_pkg::WID_32;
			c.src_item_width = dccw_pkg::WID_32;
			c.dest_burst_len = 3'(k);
			c.src_burst_len = 3'(k);
			start(c, 32'h1);
			pulse(1'b1, 1'b1);
			repeat (600) @(posedge clk);
			e = (k == 0) ? 32'h1 : (32'h1 << (k + 1));
			check(32'(u_per.nsrc - n0), e);
			check(32'(u_per.got.size() - d0), e);
			bus(1'b1, A_CMD, 32'h0);
		end
		check(32'(bbt), 32'h1);
		c = '0;
		c.dest_item_width = 3'h3;
		start(c, 32'h1);
		bus(1'b0, A_STAT, 32'h0);
		check(r & 32'h5, 32'h4);
		bus(1'b1, A_STAT, 32'h4);
		bus(1'b0, A_STAT, 32'h0);
		check(r & 32'h4, 32'h0);
		c = '0;
		c.dest_item_width = dccw_pkg::WID_8;
		c.src_item_width = dccw_pkg::WID_32;
		c.dest_burst_len = 3'h1;
		c.remaining_count = 12'h004;
		start(c, 32'h3);
		pulse(1'b1, 1'b1);
		repeat (60) @(posedge clk);
		for (k = 0; k < 4; k++)
			check(u_per.got[d0 + k], 32'(k));
		check(32'(ndone - m0), 32'h1);
		bus(1'b1, A_STAT, 32'h2);
		bus(1'b0, A_STAT, 32'h0);
		check(r & 32'h2, 32'h0);
		c = '0;
		c.dest_item_width = dccw_pkg::WID_16;
		c.src_item_width = dccw_pkg::WID_16;
		c.remaining_count = 12'h001;
		start(c, 32'h3);
		pulse(1'b1, 1'b1);
		repeat (60) @(posedge clk);
		check(u_per.got[d0], 32'h00000100);
		check(32'(ndone - m0), 32'h1);
		c.remaining_count = 12'h000;
		start(c, 32'h3);
		repeat (5) @(posedge clk);
		check(32'(ndone - m0), 32'h1);
		check(32'(active), 32'h0);
		bus(1'b1, A_STAT, 32'h2);
		bus(1'b0, A_STAT, 32'h0);
		check(r & 32'h2, 32'h0);
		c = '0;
		c.dest_item_width = dccw_pkg::WID_32;
		c.src_item_width = dccw_pkg::WID_8;
		c.src_burst_len = 3'h7;
		c.remaining_count = 12'h003;
		stall <= 1'b1;
		start(c, 32'h3);
		pulse(1'b1, 1'b1);
		repeat (60) @(posedge clk);
		check(32'(sready), 32'h0);
		check(32'(u_per.got.size() - d0), 32'h0);
		stall <= 1'b0;
		repeat (10) @(posedge clk);
		check(u_per.got[d0], 32'h0C080400);
		bus(1'b0, A_CTRL, 32'h0);
		check(32'(r[11:0]), 32'h2);
		pulse(1'b0, 1'b1);
		repeat (30) @(posedge clk);
		pulse(1'b0, 1'b1);
		repeat (30) @(posedge clk);
		check(u_per.got[d0 + 1], 32'h1C181410);
		check(u_per.got[d0 + 2], 32'h2C282420);
		check(32'(ndone - m0), 32'h1);
		check(32'(active), 32'h0);
		bus(1'b0, A_CTRL, 32'h0);
		check(32'(r[11:0]), 32'h0);
		bus(1'b0, A_STAT, 32'h0);
		check(r & 32'h2, 32'h2);
		results();
	end
endmodule
